// ---- rws_sequencer.sv ----
`timescale 1ns/100ps
`include "rws_cfg.svh"
// Behaviour
// - Mode 00: continuous receive with clock/data out.
// - Mode 01: energy wake raises interrupt above level.
// - Energy mode window timer; 0x00 gives one sample.
// - Clock recovery off until energy found.
// - After energy, search joined identifier, 32 bits max.
// - Identifier timer expiry returns to duty listen, or to standby outside duty.
// - Unbuffered match interrupts; controller takes clock/data pins.
// - Nonzero payload count buffers bits before interrupt.
// - Mode 10: correlation against sequence and identifier.
// - Match length and per-bit threshold govern correlation.
// - Single joined sequence up to 32, or sequence then identifier.
// - Pattern mode window timer bounds sequence search.
// - Identifier timer restarts on each sequence hit.
// - Identifier timer expiry alone: return to standby, or sleep under duty.
// - Plain receive expiry goes standby; controller recommands.
// - Duty listen restarts receiver every profile period.
// - Two independent receive profiles.
// - Two profile periods plus channel-check period timers.
// - Gate bit blocks FSK until RSSI over level.
// - One wake level serves FSK gate and OOK slicer.
// - Bandwidth field selects 100/200/300 kHz.
// - Amplitude pin: filtered RSSI or sliced OOK.
// - Frequency pin: discriminator or sliced FSK.
// - First profile wins collisions; second queued.
module rws_sequencer
  import rws_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [7:0]  rssi_i,
  input  wire logic        ook_slice_i,
  input  wire logic        fsk_slice_i,
  input  wire logic        rx_bit_i,
  input  wire logic        rx_clk_i,
  output logic             rx_en_o,
  output logic             profile_o,
  output logic             cdr_en_o,
  output logic             fsk_det_en_o,
  output logic [7:0]       ook_ref_o,
  output logic [1:0]       bw_sel_o,
  output logic             amplitude_pin_select_o,
  output logic             frequency_pin_select_o,
  output logic             cca_tick_o,
  output logic             recovered_clock_pin_o,
  output logic             payload_data_pin_o,
  output logic             irq_o
);
  logic [7:0]  lvl_q [2];
  logic [7:0]  gate_q;
  rws_opt_s    opt_q [2];
  logic [7:0]  win_q [2];
  logic [7:0]  idt_q [2];
  logic [15:0] per_q [2];
  logic [15:0] cca_per_q;
  logic [15:0] wake_seq_q;
  logic [15:0] node_id_q;
  rws_match_s  match_q;
  logic [7:0]  paylen_q;
  logic [1:0]  cmd_q;
  logic        cmd_stb;
  logic        irq_q;
  logic [31:0] payload_q;
  logic        ack_q;
  rws_state_e  st_q;
  logic        prof_q;
  logic [1:0]  pend_q;
  logic        duty_q;

  function automatic logic hit(input logic [7:0] a);
    hit = cyc_i && stb_i && (adr_i == a);
  endfunction : hit

  // Link clock sampled by three flops; edge once last two agree.
  logic [2:0] rclk_sync_q;
  logic [2:0] rbit_sync_q;
  logic       rclk_lvl_q;
  logic       rbit_lvl_q;
  logic       bit_stb;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rclk_sync_q <= 3'h0;
      rbit_sync_q <= 3'h0;
    end else begin
      rclk_sync_q <= {rclk_sync_q[1:0], rx_clk_i};
      rbit_sync_q <= {rbit_sync_q[1:0], rx_bit_i};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rclk_lvl_q <= 1'b0;
      rbit_lvl_q <= 1'b0;
    end else begin
      if (rclk_sync_q[2] == rclk_sync_q[1]) rclk_lvl_q <= rclk_sync_q[2];
      if (rbit_sync_q[2] == rbit_sync_q[1]) rbit_lvl_q <= rbit_sync_q[2];
    end
  end
  assign bit_stb = (rclk_sync_q[2] == rclk_sync_q[1]) && rclk_sync_q[2] && !rclk_lvl_q;

  // Wishbone classic slave: ack one cycle after strobe, dropped next.
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_q <= 1'b0;
    else ack_q <= cyc_i && stb_i && !ack_q;
  end
  assign ack_o = ack_q;
  wire wr = cyc_i && stb_i && we_i && ack_q && sel_i[0];
  assign cmd_stb = wr && (adr_i == `RWS_A_CMD);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q[0] <= `RWS_ZERO8;
      lvl_q[1] <= `RWS_ZERO8;
      gate_q <= `RWS_ZERO8;
      opt_q[0] <= '0;
      opt_q[1] <= '0;
      win_q[0] <= `RWS_ZERO8;
      win_q[1] <= `RWS_ZERO8;
      idt_q[0] <= `RWS_ZERO8;
      idt_q[1] <= `RWS_ZERO8;
      per_q[0] <= 16'h0000;
      per_q[1] <= 16'h0000;
      cca_per_q <= 16'h0000;
      wake_seq_q <= 16'h0000;
      node_id_q <= 16'h0000;
      match_q <= '0;
      paylen_q <= `RWS_ZERO8;
      cmd_q <= 2'h0;
    end else if (wr) begin
      if (hit(`RWS_A_LVL_FIRST))  lvl_q[0] <= dat_i[7:0];
      if (hit(`RWS_A_LVL_SECOND)) lvl_q[1] <= dat_i[7:0];
      if (hit(`RWS_A_GATE))       gate_q <= dat_i[7:0];
      if (hit(`RWS_A_OPT_FIRST))  opt_q[0] <= dat_i[7:0];
      if (hit(`RWS_A_OPT_SECOND)) opt_q[1] <= dat_i[7:0];
      if (hit(`RWS_A_WIN_FIRST))  win_q[0] <= dat_i[7:0];
      if (hit(`RWS_A_WIN_SECOND)) win_q[1] <= dat_i[7:0];
      if (hit(`RWS_A_IDT_FIRST))  idt_q[0] <= dat_i[7:0];
      if (hit(`RWS_A_IDT_SECOND)) idt_q[1] <= dat_i[7:0];
      if (hit(`RWS_A_PER_FIRST) && sel_i[1])  per_q[0] <= dat_i[15:0];
      if (hit(`RWS_A_PER_SECOND) && sel_i[1]) per_q[1] <= dat_i[15:0];
      if (hit(`RWS_A_CCA_PER) && sel_i[1])    cca_per_q <= dat_i[15:0];
      if (hit(`RWS_A_WAKE_SEQ) && sel_i[1])   wake_seq_q <= dat_i[15:0];
      if (hit(`RWS_A_NODE_ID) && sel_i[1])    node_id_q <= dat_i[15:0];
      if (hit(`RWS_A_MATCH) && sel_i[1])      match_q <= dat_i[11:0];
      if (hit(`RWS_A_PAYLEN))     paylen_q <= dat_i[7:0];
      if (hit(`RWS_A_CMD))        cmd_q <= dat_i[1:0];
    end
  end

  always_comb begin
    dat_o = 32'h0000_0000;
    if (ack_q && !we_i) begin
      case (adr_i)
        `RWS_A_LVL_FIRST:  dat_o = {24'h000000, lvl_q[0]};
        `RWS_A_LVL_SECOND: dat_o = {24'h000000, lvl_q[1]};
        `RWS_A_GATE:       dat_o = {24'h000000, gate_q};
        `RWS_A_OPT_FIRST:  dat_o = {24'h000000, opt_q[0]};
        `RWS_A_OPT_SECOND: dat_o = {24'h000000, opt_q[1]};
        `RWS_A_WIN_FIRST:  dat_o = {24'h000000, win_q[0]};
        `RWS_A_WIN_SECOND: dat_o = {24'h000000, win_q[1]};
        `RWS_A_IDT_FIRST:  dat_o = {24'h000000, idt_q[0]};
        `RWS_A_IDT_SECOND: dat_o = {24'h000000, idt_q[1]};
        `RWS_A_PER_FIRST:  dat_o = {16'h0000, per_q[0]};
        `RWS_A_PER_SECOND: dat_o = {16'h0000, per_q[1]};
        `RWS_A_CCA_PER:    dat_o = {16'h0000, cca_per_q};
        `RWS_A_WAKE_SEQ:   dat_o = {16'h0000, wake_seq_q};
        `RWS_A_NODE_ID:    dat_o = {16'h0000, node_id_q};
        `RWS_A_MATCH:      dat_o = {20'h00000, match_q};
        `RWS_A_PAYLEN:     dat_o = {24'h000000, paylen_q};
        `RWS_A_CMD:        dat_o = {30'h00000000, cmd_q};
        `RWS_A_STATUS:     dat_o = {24'h000000, irq_q, 1'b0, prof_q, pend_q, st_q};
        `RWS_A_PAYLOAD:    dat_o = payload_q;
        default:           dat_o = 32'h0000_0000;
      endcase
    end
  end

  // Millisecond tick shared by all window and period counters.
  logic [13:0] pre_q;
  wire         tick = (pre_q == 14'(`RWS_TICK_CYC - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) pre_q <= 14'h0000;
    else pre_q <= pre_q + 14'h0001;
  end

  // Per-profile period timers and the channel-check timer.
  logic [15:0] pcnt_q [2];
  logic [15:0] ccnt_q;
  logic [1:0]  per_exp;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_per
      assign per_exp[g] = duty_q && opt_q[g].duty_en && tick && (pcnt_q[g] == per_q[g]);
      always_ff @(posedge clk_i) begin
        if (rst_i || !duty_q || per_exp[g]) pcnt_q[g] <= 16'h0000;
        else if (tick && opt_q[g].duty_en) pcnt_q[g] <= pcnt_q[g] + 16'h0001;
      end
    end
  endgenerate
  always_ff @(posedge clk_i) begin
    if (rst_i || !duty_q || (tick && ccnt_q == cca_per_q)) ccnt_q <= 16'h0000;
    else if (tick) ccnt_q <= ccnt_q + 16'h0001;
  end
  assign cca_tick_o = duty_q && tick && (ccnt_q == cca_per_q);

  rws_opt_s   o;
  logic [7:0] lvl;
  logic       energy;
  assign o = opt_q[prof_q];
  assign lvl = lvl_q[prof_q];
  assign energy = rssi_i > lvl;

  // Correlator: shift received bits and compare with threshold of agreement.
  logic [31:0] shr_q;
  logic [5:0]  len;
  logic [31:0] lmask;
  logic [31:0] target;
  logic [5:0]  agree;
  logic        seq_hit;
  logic        id_hit;
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q == RWS_IDLE) shr_q <= 32'h0000_0000;
    else if (bit_stb) shr_q <= {shr_q[30:0], rbit_lvl_q};
  end
  assign len = (match_q.length > 6'd32) ? 6'd32 : match_q.length;
  assign lmask = (len == 6'd32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << len) - 32'h0000_0001);
  assign target = {wake_seq_q, node_id_q};
  // The shifted bits come in as an argument so that callers re-evaluate on every new bit.
  function automatic logic corr(input logic [31:0] sh, input logic [31:0] pat,
                                input logic [31:0] m, input logic [5:0] need);
    logic [5:0] s;
    s = 6'd0;
    for (int i = 0; i < 32; i++) s = s + 6'(m[i] & ~(sh[i] ^ pat[i]));
    corr = (m != 32'h0000_0000) && (s >= need);
  endfunction : corr
  assign agree = (o.mode == `RWS_MODE_PATTERN) ? {1'b0, match_q.thresh} : len;
  assign seq_hit = match_q.split ?
                   corr(shr_q, {16'h0000, wake_seq_q}, lmask & 32'h0000_FFFF, agree) :
                   corr(shr_q, target, lmask, agree);
  assign id_hit  = corr(shr_q, {16'h0000, node_id_q}, lmask & 32'h0000_FFFF, agree);

  logic [7:0] wcnt_q;
  logic [7:0] icnt_q;
  logic [7:0] bcnt_q;
  logic       win_exp;
  logic       id_exp;
  assign win_exp = (win_q[prof_q] == `RWS_ZERO8) || (tick && wcnt_q == win_q[prof_q]);
  assign id_exp  = tick && (icnt_q == idt_q[prof_q]);

  // Sequencer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= RWS_IDLE;
      prof_q <= 1'b0;
      duty_q <= 1'b0;
      wcnt_q <= `RWS_ZERO8;
      icnt_q <= `RWS_ZERO8;
      bcnt_q <= `RWS_ZERO8;
      pend_q <= 2'b00;
    end else if (cmd_stb) begin
      duty_q <= (dat_i[1:0] == `RWS_CMD_DUTY);
      st_q <= (dat_i[1:0] == `RWS_CMD_DUTY) ? RWS_SLEEP :
              (dat_i[1:0] == `RWS_CMD_RX) ? ((o.mode == `RWS_MODE_CONT) ? RWS_CONT
                                                                       : RWS_LISTEN)
                                           : RWS_IDLE;
      wcnt_q <= `RWS_ZERO8;
      pend_q <= 2'b00;
    end else begin
      pend_q <= pend_q | per_exp;
      case (st_q)
        RWS_CONT: ;
        RWS_SLEEP: begin
          if (pend_q[0] || per_exp[0]) begin
            prof_q <= 1'b0;
            pend_q[0] <= 1'b0;
            pend_q[1] <= pend_q[1] | per_exp[1];
            st_q <= RWS_LISTEN;
            wcnt_q <= `RWS_ZERO8;
          end else if (pend_q[1] || per_exp[1]) begin
            prof_q <= 1'b1;
            pend_q[1] <= 1'b0;
            st_q <= RWS_LISTEN;
            wcnt_q <= `RWS_ZERO8;
          end
        end
        RWS_LISTEN: begin
          if (tick) wcnt_q <= wcnt_q + 8'h01;
          icnt_q <= `RWS_ZERO8;
          if (o.mode == `RWS_MODE_ENERGY && energy) begin
            if (o.cdr_en && len != 6'd0) st_q <= RWS_ID_SEARCH;
            else st_q <= RWS_BUFFER;
          end else if (o.mode == `RWS_MODE_PATTERN && seq_hit) begin
            st_q <= match_q.split ? RWS_ID_SEARCH : RWS_BUFFER;
          end else if (win_exp) begin
            st_q <= duty_q ? RWS_SLEEP : RWS_IDLE;
          end
          bcnt_q <= `RWS_ZERO8;
        end
        RWS_ID_SEARCH: begin
          if (tick) icnt_q <= icnt_q + 8'h01;
          if (tick) wcnt_q <= wcnt_q + 8'h01;
          if (o.mode == `RWS_MODE_PATTERN && seq_hit && !id_hit)
            icnt_q <= `RWS_ZERO8;
          if ((o.mode == `RWS_MODE_PATTERN) ? id_hit : seq_hit)
            st_q <= RWS_BUFFER;
          else if (id_exp)
            st_q <= duty_q ? RWS_SLEEP : RWS_IDLE;
        end
        RWS_BUFFER: begin
          if (bit_stb) bcnt_q <= bcnt_q + 8'h01;
          if (paylen_q == `RWS_ZERO8 || (bit_stb && bcnt_q + 8'h01 >= paylen_q)) begin
            st_q <= RWS_IDLE;
            duty_q <= 1'b0;
            pend_q <= 2'b00;
          end
        end
        RWS_IDLE: ;
        default: st_q <= RWS_IDLE;
      endcase
    end
  end

  // Payload capture into a read register.
  always_ff @(posedge clk_i) begin
    if (rst_i) payload_q <= 32'h0000_0000;
    else if (st_q == RWS_BUFFER && bit_stb) payload_q <= {payload_q[30:0], rbit_lvl_q};
  end

  // Sticky interrupt level; set wins over the clearing write.
  wire irq_set = (st_q == RWS_BUFFER) &&
                 (paylen_q == `RWS_ZERO8 || (bit_stb && bcnt_q + 8'h01 >= paylen_q));
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_q <= 1'b0;
    else if (irq_set) irq_q <= 1'b1;
    else if (wr && hit(`RWS_A_STATUS) && dat_i[7]) irq_q <= 1'b0;
  end
  assign irq_o = irq_q;

  wire active = (st_q == RWS_LISTEN) || (st_q == RWS_ID_SEARCH) ||
                (st_q == RWS_BUFFER) || (st_q == RWS_CONT);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_en_o <= 1'b0;
      profile_o <= 1'b0;
      cdr_en_o <= 1'b0;
      fsk_det_en_o <= 1'b0;
      ook_ref_o <= `RWS_ZERO8;
      bw_sel_o <= 2'h0;
      amplitude_pin_select_o <= 1'b0;
      frequency_pin_select_o <= 1'b0;
      recovered_clock_pin_o <= 1'b0;
      payload_data_pin_o <= 1'b0;
    end else begin
      rx_en_o <= active;
      profile_o <= prof_q;
      cdr_en_o <= active && o.cdr_en &&
                  !(o.mode == `RWS_MODE_ENERGY && st_q == RWS_LISTEN);
      fsk_det_en_o <= active && !(gate_q[`RWS_GATE_EN_BIT] && !energy);
      ook_ref_o <= lvl;
      bw_sel_o <= o.bw_sel;
      amplitude_pin_select_o <= o.amp_sel;
      frequency_pin_select_o <= o.freq_sel;
      recovered_clock_pin_o <= o.cdr_en && (st_q == RWS_CONT || irq_q) && rclk_lvl_q;
      payload_data_pin_o <= o.cdr_en && (st_q == RWS_CONT || irq_q) && rbit_lvl_q;
    end
  end

  chk_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");
  chk_duty_rearm: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == RWS_SLEEP && per_exp[0] && !cmd_stb) |=> st_q == RWS_LISTEN)
    else $error("period expiry did not restart listen");
  chk_first_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == RWS_SLEEP && per_exp[0] && per_exp[1] && !cmd_stb) |=> !prof_q && pend_q[1])
    else $error("second profile not queued");
  chk_plain_standby: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == RWS_LISTEN && !duty_q && win_exp && !energy && !seq_hit && !cmd_stb)
    |=> st_q == RWS_IDLE) else $error("plain receive did not stop");
  chk_gate_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (gate_q[`RWS_GATE_EN_BIT] && !energy) |=> !fsk_det_en_o)
    else $error("fsk detector ran below level");
  chk_cdr_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == RWS_LISTEN && o.mode == `RWS_MODE_ENERGY) |=> !cdr_en_o)
    else $error("clock recovery on before energy");
  chk_irq_after_buf: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(irq_q) |-> $past(st_q) == RWS_BUFFER) else $error("interrupt before buffering");
  chk_cont_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == RWS_CONT && !cmd_stb) |=> st_q == RWS_CONT) else $error("continuous receive left");
endmodule : rws_sequencer

// ---- rws_cfg.svh ----
`ifndef RWS_CFG_SVH
`define RWS_CFG_SVH
// Register byte addresses on the Wishbone slave.
`define RWS_A_LVL_FIRST   8'h16
`define RWS_A_LVL_SECOND  8'h36
`define RWS_A_GATE        8'h5E
`define RWS_A_CMD         8'h00
`define RWS_A_OPT_FIRST   8'h04
`define RWS_A_OPT_SECOND  8'h08
`define RWS_A_WIN_FIRST   8'h0C
`define RWS_A_WIN_SECOND  8'h10
`define RWS_A_IDT_FIRST   8'h14
`define RWS_A_IDT_SECOND  8'h18
`define RWS_A_PER_FIRST   8'h1C
`define RWS_A_PER_SECOND  8'h20
`define RWS_A_CCA_PER     8'h24
`define RWS_A_WAKE_SEQ    8'h28
`define RWS_A_NODE_ID     8'h2C
`define RWS_A_MATCH       8'h30
`define RWS_A_PAYLEN      8'h34
`define RWS_A_STATUS      8'h38
`define RWS_A_PAYLOAD     8'h3C
// Field positions.
`define RWS_GATE_EN_BIT   2
`define RWS_CMD_RX        2'h1
`define RWS_CMD_DUTY      2'h2
`define RWS_MODE_CONT     2'h0
`define RWS_MODE_ENERGY   2'h1
`define RWS_MODE_PATTERN  2'h2
// One window tick is 1 ms at the 10 MHz clock.
`define RWS_TICK_NS       1000000
`define RWS_CLK_NS        100
`define RWS_TICK_CYC      (`RWS_TICK_NS / `RWS_CLK_NS)
`define RWS_ZERO8         8'h00
`endif

// ---- rws_pkg.sv ----
package rws_pkg;
  typedef enum logic [2:0] {
    RWS_IDLE, RWS_LISTEN, RWS_ID_SEARCH, RWS_BUFFER, RWS_CONT, RWS_SLEEP
  } rws_state_e;
  // Per-profile options: mode, CLOCK_DATA_RECOVERY enable, pin selects, bandwidth.
  typedef struct packed {
    logic [1:0] bw_sel;
    logic       freq_sel;
    logic       amp_sel;
    logic       cdr_en;
    logic       duty_en;
    logic [1:0] mode;
  } rws_opt_s;
  typedef struct packed {
    logic [4:0] thresh;
    logic [5:0] length;
    logic       split;
  } rws_match_s;
endpackage : rws_pkg

// ---- rws_far_model.sv ----
`timescale 1ns/100ps
module rws_far_model (
  output logic rx_clk_o,
  output logic rx_bit_o
);
  initial begin
    rx_clk_o = 1'b0;
    rx_bit_o = 1'b1;
  end
  // Sends n bits MSB first at 800 ns a bit; the clock stands still between frames.
  // The first delay keeps the link edges off the system clock edges.
  task automatic send(input logic [15:0] data, input int n);
    int i;
    #37;
    for (i = n - 1; i >= 0; i--) begin
      rx_bit_o = data[i];
      #400;
      rx_clk_o = 1'b1;
      #400;
      rx_clk_o = 1'b0;
    end
    rx_bit_o = ~data[0];
  endtask : send
endmodule : rws_far_model

// ---- test_rx_wake_sniff_sequencer.sv ----
`timescale 1ns/100ps
`include "rws_cfg.svh"
module test_rx_wake_sniff_sequencer
  import rws_pkg::*;
;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i, rssi_i, ook_ref_o;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic        rx_bit_i, rx_clk_i, rx_en_o, profile_o, cdr_en_o, fsk_det_en_o;
  logic [1:0]  bw_sel_o;
  logic        amp_o, freq_o, cca_tick_o, rclk_o, rdat_o, irq_o;
  int          n_mismatch, tests_run, b;

  rws_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .rssi_i(rssi_i), .ook_slice_i(1'b0), .fsk_slice_i(1'b0),
    .rx_bit_i(rx_bit_i), .rx_clk_i(rx_clk_i), .rx_en_o(rx_en_o), .profile_o(profile_o),
    .cdr_en_o(cdr_en_o), .fsk_det_en_o(fsk_det_en_o), .ook_ref_o(ook_ref_o),
    .bw_sel_o(bw_sel_o), .amplitude_pin_select_o(amp_o), .frequency_pin_select_o(freq_o),
    .cca_tick_o(cca_tick_o), .recovered_clock_pin_o(rclk_o), .payload_data_pin_o(rdat_o),
    .irq_o(irq_o));

  rws_far_model far (.rx_clk_o(rx_clk_i), .rx_bit_o(rx_bit_i));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic test_done();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One classic Wishbone cycle; read data is taken at the edge that samples ack.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    for (i = 0; i < 100; i++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    if (i == 100) begin
      check(32'h0, 32'h1);
      test_done();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  function automatic logic pick(input int s);
    case (s)
      0: return rx_en_o;
      1: return cdr_en_o;
      2: return irq_o;
      4: return rclk_o;
      5: return cca_tick_o;
      default: return fsk_det_en_o;
    endcase
  endfunction : pick

  task automatic wait_for(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_i);
      if (pick(s) === v) break;
    end
    if (i == lim) begin
      check({31'h0, pick(s)}, {31'h0, v});
      test_done();
    end
  endtask : wait_for

  initial begin
    repeat (100000) @(posedge clk_i);
    check(32'h0, 32'h1);
    test_done();
  end

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i} = 3'h0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = 32'h0;
    rssi_i = 8'h10;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({31'h0, rx_en_o}, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    wb(1'b1, `RWS_A_LVL_FIRST, 32'h40, rd);
    wb(1'b1, `RWS_A_LVL_SECOND, 32'h5A, rd);
    wb(1'b1, `RWS_A_GATE, 32'h04, rd);
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF, rd);
    wb(1'b0, `RWS_A_LVL_FIRST, 32'h0, rd);
    check({24'h0, rd[7:0]}, 32'h40);
    wb(1'b0, `RWS_A_LVL_SECOND, 32'h0, rd);
    check({24'h0, rd[7:0]}, 32'h5A);
    wb(1'b0, `RWS_A_GATE, 32'h0, rd);
    check({24'h0, rd[7:0]}, 32'h04);
    wb(1'b0, 8'hFC, 32'h0, rd);
    check(rd, 32'h0);
    // Continuous receive with bandwidth codes 0 to 2 and both pin selections.
    for (b = 0; b < 3; b++) begin
      wb(1'b1, `RWS_A_OPT_FIRST, {24'h0, b[1:0], b[0], ~b[0], 4'h8}, rd);
      wb(1'b1, `RWS_A_CMD, 32'h1, rd);
      wait_for(0, 1'b1, 50);
      repeat (4) @(posedge clk_i);
      check({30'h0, bw_sel_o}, b);
      check({31'h0, amp_o}, {31'h0, ~b[0]});
      check({31'h0, freq_o}, {31'h0, b[0]});
      check({31'h0, cdr_en_o}, 32'h1);
    end
    check({31'h0, fsk_det_en_o}, 32'h0);
    check({24'h0, ook_ref_o}, 32'h40);
    rssi_i <= 8'h80;
    wait_for(3, 1'b1, 20);
    rssi_i <= 8'h10;
    wb(1'b1, `RWS_A_GATE, 32'h0, rd);
    repeat (4) @(posedge clk_i);
    check({31'h0, fsk_det_en_o}, 32'h1);
    wb(1'b1, `RWS_A_CMD, 32'h0, rd);
    wait_for(0, 1'b0, 50);
    // Energy wake, 8-bit identifier 0xA5, then 8 buffered payload bits.
    wb(1'b1, `RWS_A_WIN_FIRST, 32'h5, rd);
    wb(1'b1, `RWS_A_IDT_FIRST, 32'h5, rd);
    wb(1'b1, `RWS_A_WAKE_SEQ, 32'h0, rd);
    wb(1'b1, `RWS_A_NODE_ID, 32'hA5, rd);
    wb(1'b1, `RWS_A_MATCH, 32'h10, rd);
    wb(1'b1, `RWS_A_PAYLEN, 32'h8, rd);
    wb(1'b1, `RWS_A_OPT_FIRST, 32'h09, rd);
    wb(1'b1, `RWS_A_CMD, 32'h1, rd);
    wait_for(0, 1'b1, 50);
    repeat (20) @(posedge clk_i);
    check({31'h0, cdr_en_o}, 32'h0);
    rssi_i <= 8'h80;
    wait_for(1, 1'b1, 100);
    far.send(16'h0A5C, 12);
    repeat (8) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    far.send(16'h3, 4);
    wait_for(2, 1'b1, 50);
    wb(1'b0, `RWS_A_PAYLOAD, 32'h0, rd);
    check({24'h0, rd[7:0]}, 32'hC3);
    wb(1'b0, `RWS_A_STATUS, 32'h0, rd);
    check({31'h0, rd[7]}, 32'h1);
    wb(1'b1, `RWS_A_STATUS, 32'h80, rd);
    wait_for(2, 1'b0, 10);
    // Unbuffered match: interrupt at once, then clock and data appear on the pins.
    wb(1'b1, `RWS_A_PAYLEN, 32'h0, rd);
    wb(1'b1, `RWS_A_CMD, 32'h1, rd);
    far.send(16'h00A5, 8);
    wait_for(2, 1'b1, 50);
    fork
      far.send(16'h0001, 1);
      begin
        wait_for(4, 1'b1, 30);
        check({31'h0, rdat_o}, 32'h1);
      end
    join
    wb(1'b1, `RWS_A_STATUS, 32'h80, rd);
    wait_for(2, 1'b0, 10);
    // Pattern wake: 8-bit sequence, then 8-bit identifier, full agreement needed.
    wb(1'b1, `RWS_A_OPT_FIRST, 32'h02, rd);
    wb(1'b1, `RWS_A_WAKE_SEQ, 32'hA5, rd);
    wb(1'b1, `RWS_A_NODE_ID, 32'h3C, rd);
    wb(1'b1, `RWS_A_MATCH, 32'h411, rd);
    wb(1'b1, `RWS_A_CMD, 32'h1, rd);
    wait_for(0, 1'b1, 50);
    far.send(16'hA53C, 16);
    wait_for(2, 1'b1, 50);
    wb(1'b1, `RWS_A_STATUS, 32'h80, rd);
    wait_for(2, 1'b0, 10);
    wb(1'b1, `RWS_A_CMD, 32'h0, rd);
    rssi_i <= 8'h10;
    // Plain receive: a window of 1 to 2 ms (window register 1) with no energy ends in standby.
    wb(1'b1, `RWS_A_OPT_FIRST, 32'h01, rd);
    wb(1'b1, `RWS_A_WIN_FIRST, 32'h1, rd);
    wb(1'b1, `RWS_A_CMD, 32'h1, rd);
    wait_for(0, 1'b1, 50);
    repeat (5000) @(posedge clk_i);
    check({31'h0, rx_en_o}, 32'h1);
    wait_for(0, 1'b0, 16000);
    repeat (200) @(posedge clk_i);
    check({31'h0, rx_en_o}, 32'h0);
    // Duty-cycled listen, both profiles every 2 ms with single-sample windows.
    wb(1'b1, `RWS_A_OPT_SECOND, 32'h05, rd);
    wb(1'b1, `RWS_A_PER_SECOND, 32'h1, rd);
    wb(1'b1, `RWS_A_OPT_FIRST, 32'h05, rd);
    wb(1'b1, `RWS_A_PER_FIRST, 32'h1, rd);
    wb(1'b1, `RWS_A_WIN_FIRST, 32'h0, rd);
    wb(1'b1, `RWS_A_CMD, 32'h2, rd);
    wait_for(5, 1'b1, 12000);
    wait_for(0, 1'b1, 25000);
    check({31'h0, profile_o}, 32'h0);
    wait_for(0, 1'b0, 5);
    wait_for(0, 1'b1, 10);
    check({31'h0, profile_o}, 32'h1);
    wait_for(0, 1'b0, 5);
    wait_for(0, 1'b1, 25000);
    check({31'h0, profile_o}, 32'h0);
    wb(1'b1, `RWS_A_CMD, 32'h0, rd);
    test_done();
  end
endmodule : test_rx_wake_sniff_sequencer
